// ==== design/typec_cc_pkg.sv ====
// Shared constants and types for the Type-C configuration-channel controller
package typec_cc_pkg;

  // Timebase
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;

  // CC attach debounce, bus-power debounce, dual-role toggle period
  localparam int unsigned T_CC_DB_MS   = 133;
  localparam int unsigned CC_DB_CYC    = T_CC_DB_MS * CYC_PER_MS;
  localparam int unsigned T_VBUS_DB_MS = 2;
  localparam int unsigned VBUS_DB_CYC  = T_VBUS_DB_MS * CYC_PER_MS;
  localparam int unsigned T_DRP_MS     = 75;
  localparam int unsigned DRP_CYC      = T_DRP_MS * CYC_PER_MS;
  localparam int unsigned DRP_SRC_PCT  = 30;

  // Register byte offsets
  localparam logic [3:0]  CTRL_OFS     = 4'h0;
  localparam logic [3:0]  STAT_OFS     = 4'h4;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

  // Control and status field positions
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_CFG_LSB   = 3;
  localparam int unsigned ST_ORIENT    = 5;
  localparam int unsigned ST_VCONN1    = 6;
  localparam int unsigned ST_VCONN2    = 7;
  localparam int unsigned ST_VBUS      = 8;
  localparam int unsigned ST_IND_A     = 9;
  localparam int unsigned ST_IND_B     = 10;
  localparam int unsigned ST_ATTACH    = 11;

  // Tri-level pin codes from the level sensors
  localparam logic [1:0]  TRI_LOW      = 2'h0;
  localparam logic [1:0]  TRI_MID      = 2'h1;
  localparam logic [1:0]  TRI_HIGH     = 2'h2;

  // Pull-up current levels, seen on CC or advertised
  localparam logic [1:0]  RP_NONE      = 2'h0;
  localparam logic [1:0]  RP_DEF       = 2'h1;
  localparam logic [1:0]  RP_1A5       = 2'h2;
  localparam logic [1:0]  RP_3A        = 2'h3;

  typedef enum logic [2:0] {
    UNATT_SNK, AW_SNK, ATT_SNK, UNATT_SRC, AW_SRC, ATT_SRC
  } cc_state_t;

  typedef enum logic [1:0] {CFG_UFP, CFG_DFP, CFG_DRP} port_cfg_t;

endpackage

// ==== design/level_filter.sv ====
// Debounce filter: output rises after the input has held high long enough
`timescale 1ns/10ps
module level_filter
  import typec_cc_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic level_i,
  output logic      stable_o
);
  localparam int unsigned W = $clog2(HOLD_CYC + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         stable;
  } filt_t;

  filt_t s_q;
  filt_t s_d;

  // A single low sample restarts the wait; the drop itself is not filtered
  always_comb begin
    s_d = s_q;
    if (!level_i) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != W'(HOLD_CYC - 1)) begin
      s_d.cnt = s_q.cnt + W'(1);
    end
    s_d.stable = level_i && (s_q.cnt == W'(HOLD_CYC - 1));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stable_o = s_q.stable;
endmodule

// ==== design/typec_cc_port_controller.sv ====
// Type-C CC port controller: role flow, current, orientation, cable power
//
// Contract
// - Role pin read as floating makes the port dual-role
// - Unattached dual-role port alternates between full source and sink
// - Sink shows detected current on indicators A and B per level
// - Source advertises default, 1.5 A or 3 A from current-select pin
// - Sink attach needs valid bus power; bus power decides sink detach
// - Dual-role port uses bus power to resolve its final role
// - Orientation pin driven low for CC1, released high for CC2
// - Cable power on unused CC only in Attached.SRC with Ra there
// - Cable power removed once Attached.SRC is left, on Rd loss or port disable
// - Unattached states per configuration, dual-role toggles SNK to SRC
// - Active state is Attached.SNK or Attached.SRC per resolved role
// - Start in Unattached.SNK, then follow the sampled configuration
// - Role pin sampled only after reset, held until next reset
// - Attach indicator tells host of a source attach
// - Leave active on unplug, and as sink also on bus power loss
// - CC levels debounced 133 ms before an attach is accepted
// - Bus-power sense debounced 2 ms after reaching valid level
// - Dual-role toggle presents as source 30 percent of each period
// - Full dual-role toggle period nominally 75 ms, 50 to 100 ms
`timescale 1ns/10ps
module typec_cc_port_controller
  import typec_cc_pkg::*;
#(
  parameter int unsigned CC_DB_CYC_P   = CC_DB_CYC,
  parameter int unsigned VBUS_DB_CYC_P = VBUS_DB_CYC,
  parameter int unsigned DRP_CYC_P     = DRP_CYC,
  parameter int unsigned DRP_SRC_PCT_P = DRP_SRC_PCT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  role_sel_i,
  input  wire logic [1:0]  cur_sel_i,
  input  wire logic        bus_power_sense_i,
  input  wire logic [1:0]  cc1_rp_lvl_i,
  input  wire logic [1:0]  cc2_rp_lvl_i,
  input  wire logic        cc1_rd_i,
  input  wire logic        cc2_rd_i,
  input  wire logic        cc1_ra_i,
  input  wire logic        cc2_ra_i,
  output logic             cc_rp_en_o,
  output logic             cc_rd_en_o,
  output logic      [1:0]  rp_adv_o,
  output logic             dir_o,
  output logic             dir_oe_o,
  output logic             vconn_cc1_o,
  output logic             vconn_cc2_o,
  output logic             attach_indicator_o,
  output logic             sink_level_ind_a_o,
  output logic             sink_level_ind_b_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  localparam int unsigned TOG_W   = $clog2(DRP_CYC_P + 1);
  localparam int unsigned SRC_CYC = DRP_CYC_P * DRP_SRC_PCT_P / 100;
  localparam int unsigned SNK_CYC = DRP_CYC_P - SRC_CYC;

  typedef struct packed {
    cc_state_t         state;
    port_cfg_t         cfg;
    logic              cfg_valid;
    logic [TOG_W-1:0]  tog_cnt;
    logic              orient;
    logic              vconn1;
    logic              vconn2;
    logic              ind_a;
    logic              ind_b;
    logic              attach_ind;
    logic              dir_oe;
    logic [1:0]        rp_adv;
    logic              port_en;
    logic              ack;
    logic [31:0]       rdat;
  } ctrl_t;

  ctrl_t s_q;
  ctrl_t s_d;
  logic  cc_cond;
  logic  cc_stable;
  logic  vbus_ok;
  logic [1:0] rp_act;
  logic       rd_act;
  logic       drp;

  // Value on the CC pin that orientation selects
  function automatic logic [1:0] pick_cc(input logic o,
                                         input logic [1:0] v1,
                                         input logic [1:0] v2);
    return o ? v2 : v1;
  endfunction

  // Where the flow resumes after leaving attach-wait or active
  function automatic cc_state_t unatt_for(input port_cfg_t c);
    return (c == CFG_DFP) ? UNATT_SRC : UNATT_SNK;
  endfunction

  // Sink current indication as {A, B}
  function automatic logic [1:0] ind_code(input logic [1:0] lvl);
    case (lvl)
      RP_1A5:  ind_code = 2'b01;
      RP_3A:   ind_code = 2'b00;
      default: ind_code = 2'b10;
    endcase
  endfunction

  assign drp    = (s_q.cfg == CFG_DRP);
  assign rp_act = pick_cc(s_q.orient, cc1_rp_lvl_i, cc2_rp_lvl_i);
  assign rd_act = s_q.orient ? cc2_rd_i : cc1_rd_i;

  // Only the attach-wait states feed the CC debounce
  always_comb begin
    cc_cond = 1'b0;
    if (s_q.state == AW_SNK) begin
      cc_cond = (rp_act != RP_NONE);
    end else if (s_q.state == AW_SRC) begin
      cc_cond = rd_act;
    end
  end

  level_filter #(.HOLD_CYC(CC_DB_CYC_P)) u_cc_filt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .level_i  (cc_cond),
    .stable_o (cc_stable)
  );

  level_filter #(.HOLD_CYC(VBUS_DB_CYC_P)) u_vbus_filt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .level_i  (bus_power_sense_i),
    .stable_o (vbus_ok)
  );

  always_comb begin
    s_d      = s_q;
    s_d.ack  = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.rdat = '0;
    if (s_d.ack) begin
      if (wb_adr_i == CTRL_OFS) begin
        s_d.rdat[CTRL_EN_BIT] = s_q.port_en;
        if (wb_we_i && wb_sel_i[0]) begin
          s_d.port_en = wb_dat_i[CTRL_EN_BIT];
        end
      end else if (wb_adr_i == STAT_OFS) begin
        s_d.rdat[ST_STATE_LSB +: 3] = s_q.state;
        s_d.rdat[ST_CFG_LSB +: 2]   = s_q.cfg;
        s_d.rdat[ST_ORIENT]         = s_q.orient;
        s_d.rdat[ST_VCONN1]         = s_q.vconn1;
        s_d.rdat[ST_VCONN2]         = s_q.vconn2;
        s_d.rdat[ST_VBUS]           = vbus_ok;
        s_d.rdat[ST_IND_A]          = s_q.ind_a;
        s_d.rdat[ST_IND_B]          = s_q.ind_b;
        s_d.rdat[ST_ATTACH]         = s_q.attach_ind;
      end
    end

    // Role pin caught once, in the first cycle after reset
    if (!s_q.cfg_valid) begin
      s_d.cfg_valid = 1'b1;
      case (role_sel_i)
        TRI_LOW:  s_d.cfg = CFG_UFP;
        TRI_HIGH: s_d.cfg = CFG_DFP;
        default:  s_d.cfg = CFG_DRP;
      endcase
    end

    s_d.tog_cnt = s_q.tog_cnt + TOG_W'(1);

    case (s_q.state)
      UNATT_SNK: begin
        if (!s_q.cfg_valid) begin
          s_d.state = UNATT_SNK;
        end else if (s_q.cfg == CFG_DFP) begin
          s_d.state = UNATT_SRC;
        end else if (s_q.port_en && (cc1_rp_lvl_i != RP_NONE ||
                                     cc2_rp_lvl_i != RP_NONE)) begin
          s_d.state  = AW_SNK;
          s_d.orient = (cc1_rp_lvl_i == RP_NONE);
        end else if (drp && s_q.tog_cnt >= TOG_W'(SNK_CYC - 1)) begin
          s_d.state = UNATT_SRC;
        end
      end
      UNATT_SRC: begin
        if (s_q.port_en && (cc1_rd_i || cc2_rd_i)) begin
          s_d.state  = AW_SRC;
          s_d.orient = !cc1_rd_i;
        end else if (drp && s_q.tog_cnt >= TOG_W'(SRC_CYC - 1)) begin
          s_d.state = UNATT_SNK;
        end
      end
      AW_SNK: begin
        if (!s_q.port_en || rp_act == RP_NONE) begin
          s_d.state = unatt_for(s_q.cfg);
        end else if (cc_stable && vbus_ok) begin
          s_d.state = ATT_SNK;
        end
      end
      AW_SRC: begin
        if (!s_q.port_en || !rd_act) begin
          s_d.state = unatt_for(s_q.cfg);
        end else if (drp && vbus_ok) begin
          // Partner supplies bus power, so it is the source
          s_d.state  = AW_SNK;
          s_d.orient = (cc1_rp_lvl_i == RP_NONE);
        end else if (cc_stable) begin
          s_d.state = ATT_SRC;
        end
      end
      ATT_SNK: begin
        if (!s_q.port_en || !vbus_ok || rp_act == RP_NONE) begin
          s_d.state = unatt_for(s_q.cfg);
        end
      end
      ATT_SRC: begin
        if (!s_q.port_en || !rd_act) begin
          s_d.state = unatt_for(s_q.cfg);
        end
      end
      default: s_d.state = UNATT_SNK;
    endcase

    // Toggle timer restarts on every state change and keeps counting in every state
    if (s_d.state != s_q.state) begin
      s_d.tog_cnt = '0;
    end

    // Cable power set on entry to Attached.SRC, dropped on any exit from it, on Rd loss or port disable
    if (s_d.state == ATT_SRC && s_q.state != ATT_SRC) begin
      s_d.vconn1 = s_d.orient && cc1_ra_i;
      s_d.vconn2 = !s_d.orient && cc2_ra_i;
    end else if (s_d.state != ATT_SRC) begin
      s_d.vconn1 = 1'b0;
      s_d.vconn2 = 1'b0;
    end

    if (s_d.state == ATT_SNK) begin
      {s_d.ind_a, s_d.ind_b} =
        ind_code(pick_cc(s_d.orient, cc1_rp_lvl_i, cc2_rp_lvl_i));
    end else begin
      {s_d.ind_a, s_d.ind_b} = 2'b11;
    end

    s_d.attach_ind = (s_d.state == ATT_SRC);
    s_d.dir_oe = (s_d.state == ATT_SRC || s_d.state == ATT_SNK) &&
                 !s_d.orient;

    case (cur_sel_i)
      TRI_MID:  s_d.rp_adv = RP_1A5;
      TRI_HIGH: s_d.rp_adv = RP_3A;
      default:  s_d.rp_adv = RP_DEF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.state      <= UNATT_SNK;
      s_q.cfg        <= CFG_UFP;
      s_q.ind_a      <= 1'b1;
      s_q.ind_b      <= 1'b1;
      s_q.rp_adv     <= RP_DEF;
      s_q.port_en    <= CTRL_RESET[CTRL_EN_BIT];
    end else begin
      s_q <= s_d;
    end
  end

  // Rp in source states, Rd otherwise; Rd is also the power-up default
  assign cc_rp_en_o = (s_q.state == UNATT_SRC || s_q.state == AW_SRC ||
                       s_q.state == ATT_SRC);
  assign cc_rd_en_o = !cc_rp_en_o;
  assign rp_adv_o           = s_q.rp_adv;
  assign dir_o              = 1'b0;
  assign dir_oe_o           = s_q.dir_oe;
  assign vconn_cc1_o        = s_q.vconn1;
  assign vconn_cc2_o        = s_q.vconn2;
  assign attach_indicator_o = s_q.attach_ind;
  assign sink_level_ind_a_o = s_q.ind_a;
  assign sink_level_ind_b_o = s_q.ind_b;
  assign wb_dat_o           = s_q.rdat;
  assign wb_ack_o           = s_q.ack;

  a_cfg_held_stable: assert property (
    s_q.cfg_valid |=> $stable(s_q.cfg) && s_q.cfg_valid)
    else $error("port configuration changed after sampling");

  a_start_in_sink: assert property (
    !s_q.cfg_valid |-> s_q.state == UNATT_SNK)
    else $error("not in unattached sink before configuration");

  a_fixed_no_toggle: assert property (
    s_q.cfg == CFG_DFP && s_q.state == UNATT_SRC |=> s_q.state != UNATT_SNK)
    else $error("fixed source fell back to sink toggle");

  a_src_phase_len: assert property (
    drp && s_q.state == UNATT_SRC |-> s_q.tog_cnt < TOG_W'(SRC_CYC))
    else $error("source phase too long");

  a_drp_period: assert property (
    drp && s_q.state == UNATT_SNK && s_q.cfg_valid
      && !(s_q.port_en && (cc1_rp_lvl_i != RP_NONE
      || cc2_rp_lvl_i != RP_NONE))
      && s_q.tog_cnt == TOG_W'(SNK_CYC - 1) |=> s_q.state == UNATT_SRC)
    else $error("sink phase did not hand over to source");

  a_snk_needs_vbus: assert property (
    $rose(s_q.state == ATT_SNK) |-> $past(vbus_ok) && $past(cc_stable))
    else $error("sink attached without bus power or debounce");

  a_src_after_db: assert property (
    s_q.state == AW_SRC && !cc_stable |=> s_q.state != ATT_SRC)
    else $error("source attached before CC debounce");

  a_vbus_loss_exit: assert property (
    s_q.state == ATT_SNK && !vbus_ok |=> s_q.state != ATT_SNK)
    else $error("sink stayed attached without bus power");

  a_vconn_in_src: assert property (
    (s_q.vconn1 || s_q.vconn2) |-> s_q.state == ATT_SRC
      && !(s_q.vconn1 && s_q.orient == 1'b0)
      && !(s_q.vconn2 && s_q.orient == 1'b1))
    else $error("cable power outside source or on active pin");

  a_dir_follows_cc: assert property (
    dir_oe_o |-> !s_q.orient && (s_q.state == ATT_SRC
      || s_q.state == ATT_SNK))
    else $error("orientation driven low without CC1 attach");

  a_ind_levels: assert property (
    s_q.state != ATT_SNK |-> sink_level_ind_a_o && sink_level_ind_b_o)
    else $error("indicators not at unattached level");

  a_id_on_src: assert property (
    attach_indicator_o == (s_q.state == ATT_SRC))
    else $error("attach indicator disagrees with source attach");

  a_wb_one_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

endmodule

// ==== sim/cc_partner_model.sv ====
// Behavioural port partner at the far end of the CC wires
`timescale 1ns/10ps
module cc_partner_model (
  input  wire logic       as_source_i,
  input  wire logic       as_sink_i,
  input  wire logic       cable_ra_i,
  input  wire logic       flip_i,
  input  wire logic       vbus_on_i,
  input  wire logic [1:0] rp_lvl_i,
  input  wire logic       dev_rp_en_i,
  input  wire logic       dev_rd_en_i,
  output logic      [1:0] cc1_rp_lvl_o,
  output logic      [1:0] cc2_rp_lvl_o,
  output logic            cc1_rd_o,
  output logic            cc2_rd_o,
  output logic            cc1_ra_o,
  output logic            cc2_ra_o,
  output logic            bus_power_o
);
  logic [1:0] seen_lvl;
  logic       seen_rd;
  // A pull-up only shows a level while the device pulls down against it
  assign seen_lvl     = (as_source_i && dev_rd_en_i) ? rp_lvl_i : 2'h0;
  assign seen_rd      = as_sink_i && dev_rp_en_i;
  assign cc1_rp_lvl_o = flip_i ? 2'h0 : seen_lvl;
  assign cc2_rp_lvl_o = flip_i ? seen_lvl : 2'h0;
  assign cc1_rd_o     = seen_rd && !flip_i;
  assign cc2_rd_o     = seen_rd && flip_i;
  // Active cable Ra sits on the pin the partner does not use
  assign cc1_ra_o     = cable_ra_i && flip_i;
  assign cc2_ra_o     = cable_ra_i && !flip_i;
  // Only a source partner supplies bus power; unplug removes it too
  assign bus_power_o  = as_source_i && vbus_on_i;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the CC port controller
`timescale 1ns/10ps
module tb_top;
  import typec_cc_pkg::*;
  // Short counts keep the run brief; expected waits and counts are fixed for these values
  localparam int unsigned CCD = 20;
  localparam int unsigned VBD = 8;
  localparam int unsigned DRP = 100;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [1:0]  role = 2'h0, cur = 2'h0, lvl = 2'h1, l1, l2;
  logic        p_src = 1'b0, p_snk = 1'b0, p_ra = 1'b0, flip = 1'b0;
  logic        vbus = 1'b0, ack, vb, rd1, rd2, ra1, ra2, rp_en, rd_en;
  logic [1:0]  adv;
  logic        dir, dir_oe, vc1, vc2, att, ind_a, ind_b;
  int          error_cnt = 0, compares = 0, seed, n;

  always #10 clk_i = ~clk_i;

  typec_cc_port_controller #(.CC_DB_CYC_P(CCD), .VBUS_DB_CYC_P(VBD),
    .DRP_CYC_P(DRP), .DRP_SRC_PCT_P(30)) typec_cc_port_controller_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .role_sel_i(role), .cur_sel_i(cur),
    .bus_power_sense_i(vb), .cc1_rp_lvl_i(l1), .cc2_rp_lvl_i(l2),
    .cc1_rd_i(rd1), .cc2_rd_i(rd2), .cc1_ra_i(ra1), .cc2_ra_i(ra2),
    .cc_rp_en_o(rp_en), .cc_rd_en_o(rd_en), .rp_adv_o(adv), .dir_o(dir),
    .dir_oe_o(dir_oe), .vconn_cc1_o(vc1), .vconn_cc2_o(vc2),
    .attach_indicator_o(att), .sink_level_ind_a_o(ind_a),
    .sink_level_ind_b_o(ind_b));

  cc_partner_model cc_partner_model_inst (
    .as_source_i(p_src), .as_sink_i(p_snk), .cable_ra_i(p_ra),
    .flip_i(flip), .vbus_on_i(vbus), .rp_lvl_i(lvl), .dev_rp_en_i(rp_en),
    .dev_rd_en_i(rd_en), .cc1_rp_lvl_o(l1), .cc2_rp_lvl_o(l2),
    .cc1_rd_o(rd1), .cc2_rd_o(rd2), .cc1_ra_o(ra1), .cc2_ra_o(ra2),
    .bus_power_o(vb));

  // Reference model of indicator and advertisement encodings
  function automatic logic [1:0] ind_exp(input int l);
    case (l)
      2: return 2'b01;
      3: return 2'b00;
      default: return 2'b10;
    endcase
  endfunction

  function automatic logic [1:0] adv_exp(input int c);
    return (c == 1) ? 2'h2 : ((c == 2) ? 2'h3 : 2'h1);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Ends on a falling edge so outputs are settled when compared
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic count_rp(input int c);
    n = 0;
    repeat (c) begin
      @(negedge clk_i);
      n += int'(rp_en);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    // Ack and data are read as they stood at the sampling edge
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic do_reset(input logic [1:0] r);
    @(posedge clk_i);
    rst_i <= 1'b1;
    role  <= r;
    p_src <= 1'b0;
    p_snk <= 1'b0;
    p_ra  <= 1'b0;
    vbus  <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_cyc(2);
  endtask

  initial begin
    #(20 * 10000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    seed = 99265;
    do_reset(2'h0);
    chk({ind_a, ind_b, rd_en, dir_oe}, 4'b1110);
    wb(1'b1, CTRL_OFS, 32'h0, rdat);
    p_src <= 1'b1;
    lvl   <= RP_3A;
    vbus  <= 1'b1;
    role  <= 2'h2;
    wait_cyc(60);
    chk({ind_a, ind_b}, 2'b11);
    wb(1'b1, CTRL_OFS, $random(seed) | 32'h1, rdat);
    wait_cyc(60);
    chk({ind_a, ind_b, dir_oe, rd_en}, 4'b0011);
    wb(1'b0, STAT_OFS, 32'h0, rdat);
    chk(rdat[11:0], {7'b0001000, CFG_UFP, ATT_SNK});
    wb(1'b0, 4'(($random(seed) & 3) + 8), 32'h0, rdat);
    chk(rdat, 32'h0);
    @(posedge clk_i);
    vbus <= 1'b0;
    wait_cyc(5);
    chk({ind_a, ind_b, dir_oe}, 3'b110);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      lvl   <= 2'(1 + i % 3);
      flip  <= 1'(i % 2);
      p_src <= 1'b1;
      vbus  <= 1'b0;
      wait_cyc(50);
      chk({ind_a, ind_b}, 2'b11);
      @(posedge clk_i);
      vbus <= 1'b1;
      wait_cyc(6);
      chk({ind_a, ind_b}, 2'b11);
      wait_cyc(14);
      chk({ind_a, ind_b}, ind_exp(1 + i % 3));
      chk({dir, dir_oe}, {1'b0, 1'(!(i % 2))});
      @(posedge clk_i);
      p_src <= 1'b0;
      wait_cyc(5);
      chk({ind_a, ind_b, dir_oe}, 3'b110);
    end
    chk(rd_en, 1'b1);
    do_reset(2'h2);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i);
      cur <= 2'(c);
      wait_cyc(3);
      chk({rp_en, adv}, {1'b1, adv_exp(c)});
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      flip  <= 1'(i % 2);
      p_snk <= 1'b1;
      p_ra  <= (i < 2);
      wait_cyc(40);
      chk({att, vc1, vc2}, {1'b1, i == 1, i == 0});
      chk(dir_oe, 1'(!(i % 2)));
      wb(1'b0, STAT_OFS, 32'h0, rdat);
      chk({rdat[11], rdat[4:0]}, {1'b1, CFG_DFP, ATT_SRC});
      p_snk <= 1'b0;
      p_ra  <= 1'b0;
      wait_cyc(5);
      chk({att, vc1, vc2, dir_oe}, 4'b0000);
    end
    do_reset(2'h1);
    count_rp(2 * DRP);
    chk(n, 60);
    @(posedge clk_i);
    p_src <= 1'b1;
    lvl   <= RP_1A5;
    vbus  <= 1'b1;
    wait_cyc(200);
    chk({ind_a, ind_b, att}, 3'b010);
    count_rp(DRP);
    chk(n, 0);
    @(posedge clk_i);
    p_src <= 1'b0;
    wait_cyc(5);
    chk({ind_a, ind_b}, 2'b11);
    count_rp(2 * DRP);
    chk(n, 60);
    @(posedge clk_i);
    p_snk <= 1'b1;
    p_ra  <= 1'b1;
    wait_cyc(250);
    chk({att, vc1, vc2}, 3'b101);
    do_reset(2'h3);
    count_rp(3 * DRP);
    chk(n, 90);
    wrap_up();
  end
endmodule
